// >>> src/pla_map.vh
// Register map, field positions and reset values of the programmable logic fabric
`ifndef PLA_MAP_VH
`define PLA_MAP_VH

// Byte offsets on the register bus
`define PLA_OFS_ELEM_BASE 8'h00
`define PLA_OFS_CLK_SEL 8'h40
`define PLA_OFS_IRQ_ROUTE 8'h44
`define PLA_OFS_ADC_ROUTE 8'h48
`define PLA_OFS_DATA_IN 8'h4c
`define PLA_OFS_DATA_OUT 8'h50

// Element control fields
`define PLA_EL_W 11
`define PLA_EL_MUX0_HI 10
`define PLA_EL_MUX0_LO 9
`define PLA_EL_MUX1_HI 8
`define PLA_EL_MUX1_LO 7
`define PLA_EL_USE_FB1 6
`define PLA_EL_USE_PIN 5
`define PLA_EL_LUT_HI 4
`define PLA_EL_LUT_LO 1
`define PLA_EL_BYPASS 0

// Clock select fields and codes
`define PLA_CLK_B0_LO 0
`define PLA_CLK_B1_LO 4
`define PLA_CLK_SRC_P05 3'h0
`define PLA_CLK_SRC_P00 3'h1
`define PLA_CLK_SRC_P07 3'h2
`define PLA_CLK_SRC_SYS 3'h3
`define PLA_CLK_SRC_OSC 3'h4
`define PLA_CLK_SRC_TMR1 3'h5

// Routing fields
`define PLA_IRQA_SRC_LO 0
`define PLA_IRQA_EN 4
`define PLA_IRQB_SRC_LO 8
`define PLA_IRQB_EN 12
`define PLA_ADC_SRC_LO 0
`define PLA_ADC_EN 4

// Reset values
`define PLA_RST_ELEM 11'h000
`define PLA_RST_CLK 7'h00
`define PLA_RST_IRQ 13'h0000
`define PLA_RST_ADC 5'h00
`define PLA_RST_DIN 16'h0000

`endif

// >>> src/pla_sync2.v
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module pla_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Levels
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule
`default_nettype wire

// >>> src/pla_element.v
// One fabric element: two-input lookup table and optional flip-flop
`timescale 1ns/10ps
`default_nettype none
module pla_element (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Capture strobe from the block's selected clock
  input wire cap,
  // Lookup inputs
  input wire in_a,
  input wire in_b,
  // Configuration
  input wire [3:0] func,
  input wire bypass,
  // Result
  output wire elem_out
);
  reg lut_out;
  reg ff_q;

  // Fixed function per lookup code
  always @* begin
    case (func)
      4'h0: lut_out = 1'b0;
      4'h1: lut_out = ~(in_a | in_b);
      4'h2: lut_out = in_a & ~in_b;
      4'h3: lut_out = ~in_a;
      4'h4: lut_out = ~in_a & in_b;
      4'h5: lut_out = ~in_b;
      4'h6: lut_out = in_a ^ in_b;
      4'h7: lut_out = ~(in_a & in_b);
      4'h8: lut_out = in_a & in_b;
      4'h9: lut_out = ~(in_a ^ in_b);
      4'ha: lut_out = in_b;
      4'hb: lut_out = ~in_a | in_b;
      4'hc: lut_out = in_a;
      4'hd: lut_out = in_a | ~in_b;
      4'he: lut_out = in_a | in_b;
      4'hf: lut_out = 1'b1;
      default: lut_out = 1'b0;
    endcase
  end

  // Flip-flop advances only on the selected clock's rising edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_q <= 1'b0;
    end else if (cap) begin
      ff_q <= lut_out;
    end
  end

  // Bypass hands the lookup straight through
  assign elem_out = bypass ? lut_out : ff_q;
endmodule
`default_nettype wire

// >>> src/pla_fabric.v
// Programmable logic fabric: sixteen elements, routing and APB register file
//
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pla_map.vh"
module pla_fabric #(
  parameter N_ELEM = 16,
  parameter BLK_SIZE = 8
) (
  // System clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output wire [31:0] prdata,
  // Dedicated element input pins, comparator among them
  input wire [15:0] fabric_pin_in,
  // Candidate flip-flop clocks from outside
  input wire gpio_clk_p05,
  input wire gpio_clk_p00,
  input wire gpio_clk_p07,
  input wire oscillator_clock,
  input wire timer1_tick,
  // Element output pins, elements 0-5 then 8-15
  output wire [13:0] fabric_pin_out,
  // Routed outputs
  output wire fabric_interrupt_a,
  output wire fabric_interrupt_b,
  output wire adc_conversion_start
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  //
  // Every pin and every candidate clock source arrives from outside
  // the pclk domain. One shared two-stage synchroniser keeps them
  // aligned with each other, so an element reading a pin and a clock
  // strobe sees both at the same latency. The cost is two cycles of
  // delay on every pin before the lookup tables see it.
  ////////////////////////////////////////////////////////////////////////////

  wire [20:0] raw_in;
  wire [20:0] sync_in;
  wire [15:0] pin_s;
  wire [4:0] clk_s;
  reg [4:0] clk_prev_q;
  wire [4:0] clk_rise;

  // All pins are asynchronous to pclk and pass two flip-flops first
  assign raw_in = {timer1_tick, oscillator_clock, gpio_clk_p07, gpio_clk_p00,
                   gpio_clk_p05, fabric_pin_in};

  pla_sync2 #(
    .WIDTH(21)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign pin_s = sync_in[15:0];
  assign clk_s = sync_in[20:16];

  // Edge detect works on the synchronised copy only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q <= 5'h00;
    end else begin
      clk_prev_q <= clk_s;
    end
  end

  assign clk_rise = clk_s & ~clk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  //
  // Sixteen element words plus five shared words make up the map.
  // Element words sit at four-byte steps from the base, the shared
  // words follow them. Only implemented bits are stored; everything
  // else reads back as zero and ignores writes, so software may write
  // whole words without masking. The data output word is read only,
  // and a write to it completes without an error response.
  ////////////////////////////////////////////////////////////////////////////

  reg [`PLA_EL_W-1:0] elem_ctrl_q [0:N_ELEM-1];
  reg [6:0] clk_sel_q;
  reg [12:0] irq_route_q;
  reg [4:0] adc_route_q;
  reg [15:0] data_in_q;
  reg [15:0] data_out_q;

  wire apb_setup;
  wire apb_access;
  wire apb_wr;
  wire elem_hit;
  wire [3:0] elem_idx;
  reg addr_hit;

  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign apb_wr = apb_access & pwrite & addr_hit;
  assign elem_hit = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00);
  assign elem_idx = paddr[5:2];

  // Decode the twenty-one word addresses
  always @* begin
    addr_hit = 1'b0;
    if (elem_hit) begin
      addr_hit = 1'b1;
    end else begin
      case (paddr)
        `PLA_OFS_CLK_SEL: addr_hit = 1'b1;
        `PLA_OFS_IRQ_ROUTE: addr_hit = 1'b1;
        `PLA_OFS_ADC_ROUTE: addr_hit = 1'b1;
        `PLA_OFS_DATA_IN: addr_hit = 1'b1;
        `PLA_OFS_DATA_OUT: addr_hit = 1'b1;
        default: addr_hit = 1'b0;
      endcase
    end
  end

  // Element control words; reserved bits 31-11 are not stored
  genvar gi;
  generate
    for (gi = 0; gi < N_ELEM; gi = gi + 1) begin : g_ctrl
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          elem_ctrl_q[gi] <= `PLA_RST_ELEM;
        end else if (apb_wr && elem_hit && (elem_idx == gi)) begin
          elem_ctrl_q[gi] <= pwdata[`PLA_EL_W-1:0];
        end
      end
    end
  endgenerate

  // Shared routing and data registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_q <= `PLA_RST_CLK;
      irq_route_q <= `PLA_RST_IRQ;
      adc_route_q <= `PLA_RST_ADC;
      data_in_q <= `PLA_RST_DIN;
    end else if (apb_wr) begin
      case (paddr)
        `PLA_OFS_CLK_SEL: clk_sel_q <= {pwdata[6:4], 1'b0, pwdata[2:0]};
        `PLA_OFS_IRQ_ROUTE: irq_route_q <= {pwdata[12:8], 3'h0, pwdata[4:0]};
        `PLA_OFS_ADC_ROUTE: adc_route_q <= pwdata[4:0];
        `PLA_OFS_DATA_IN: data_in_q <= pwdata[15:0];
        default: clk_sel_q <= clk_sel_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block clock selection
  //
  // The design keeps a single clock. A selected source does not clock
  // the element flip-flops directly; its synchronised rising edge
  // becomes a one-cycle capture strobe. This avoids extra clock trees
  // and domain crossings, but limits every external source to well
  // below half of pclk, with high and low phases of two cycles each.
  // The system clock code captures on every pclk edge.
  ////////////////////////////////////////////////////////////////////////////

  wire [1:0] blk_cap;

  // Map a clock source code to a capture strobe; reserved codes never capture
  function sel_tick;
    input [2:0] code;
    input [4:0] rise;
    begin
      case (code)
        `PLA_CLK_SRC_P05: sel_tick = rise[0];
        `PLA_CLK_SRC_P00: sel_tick = rise[1];
        `PLA_CLK_SRC_P07: sel_tick = rise[2];
        `PLA_CLK_SRC_SYS: sel_tick = 1'b1;
        `PLA_CLK_SRC_OSC: sel_tick = rise[3];
        `PLA_CLK_SRC_TMR1: sel_tick = rise[4];
        default: sel_tick = 1'b0;
      endcase
    end
  endfunction

  // Slow sources are sampled, so they must stay well below half of pclk
  assign blk_cap[0] = sel_tick(clk_sel_q[`PLA_CLK_B0_LO+2:`PLA_CLK_B0_LO], clk_rise);
  assign blk_cap[1] = sel_tick(clk_sel_q[`PLA_CLK_B1_LO+2:`PLA_CLK_B1_LO], clk_rise);

  ////////////////////////////////////////////////////////////////////////////
  // Element array
  //
  // Elements are numbered block by block. Within a block, the first
  // feedback mux reaches the even elements and the second the odd
  // ones. Element 0 and element 8 replace their own block's base on
  // code 00 by the last element of the other block, which is the only
  // path between the two blocks.
  ////////////////////////////////////////////////////////////////////////////

  wire [N_ELEM-1:0] elem_out;

  // Bypassed elements feeding each other form loops; software avoids them
  generate
    for (gi = 0; gi < N_ELEM; gi = gi + 1) begin : g_elem
      localparam integer BASE = (gi / BLK_SIZE) * BLK_SIZE;
      localparam integer XLINK = (gi == 0) ? (N_ELEM - 1) : (BASE - 1);
      localparam integer SRC0 = (gi == 0 || gi == BLK_SIZE) ? XLINK : BASE;
      wire [`PLA_EL_W-1:0] ctrl;
      reg fb0;
      reg fb1;
      wire in_a;
      wire in_b;

      assign ctrl = elem_ctrl_q[gi];

      // First feedback mux: even elements, cross-link on code 00 for elements 0 and 8
      always @* begin
        case (ctrl[`PLA_EL_MUX0_HI:`PLA_EL_MUX0_LO])
          2'h0: fb0 = elem_out[SRC0];
          2'h1: fb0 = elem_out[BASE+2];
          2'h2: fb0 = elem_out[BASE+4];
          2'h3: fb0 = elem_out[BASE+6];
          default: fb0 = 1'b0;
        endcase
      end

      // Second feedback mux: odd elements of the own block
      always @* begin
        case (ctrl[`PLA_EL_MUX1_HI:`PLA_EL_MUX1_LO])
          2'h0: fb1 = elem_out[BASE+1];
          2'h1: fb1 = elem_out[BASE+3];
          2'h2: fb1 = elem_out[BASE+5];
          2'h3: fb1 = elem_out[BASE+7];
          default: fb1 = 1'b0;
        endcase
      end

      assign in_a = ctrl[`PLA_EL_USE_PIN] ? pin_s[gi] : fb0;
      assign in_b = ctrl[`PLA_EL_USE_FB1] ? fb1 : data_in_q[gi];

      pla_element u_elem (
        .pclk(pclk),
        .presetn(presetn),
        .cap(blk_cap[gi / BLK_SIZE]),
        .in_a(in_a),
        .in_b(in_b),
        .func(ctrl[`PLA_EL_LUT_HI:`PLA_EL_LUT_LO]),
        .bypass(ctrl[`PLA_EL_BYPASS]),
        .elem_out(elem_out[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Output routing
  //
  // Pins, interrupt lines and the conversion start are levels, one
  // cycle behind the element outputs. Registering them removes the
  // hazards of the lookup tables from the pins, at the cost of that
  // cycle. An interrupt controller that wants pulses must detect the
  // edge itself.
  ////////////////////////////////////////////////////////////////////////////

  reg [13:0] pin_out_q;
  reg irq_a_q;
  reg irq_b_q;
  reg adc_start_q;

  // Registered so pins and routed lines are glitch free
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= 14'h0000;
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      adc_start_q <= 1'b0;
      data_out_q <= 16'h0000;
    end else begin
      pin_out_q <= {elem_out[15:8], elem_out[5:0]};
      irq_a_q <= irq_route_q[`PLA_IRQA_EN] &
                 elem_out[irq_route_q[`PLA_IRQA_SRC_LO+3:`PLA_IRQA_SRC_LO]];
      irq_b_q <= irq_route_q[`PLA_IRQB_EN] &
                 elem_out[irq_route_q[`PLA_IRQB_SRC_LO+3:`PLA_IRQB_SRC_LO]];
      adc_start_q <= adc_route_q[`PLA_ADC_EN] &
                     elem_out[adc_route_q[`PLA_ADC_SRC_LO+3:`PLA_ADC_SRC_LO]];
      data_out_q <= elem_out;
    end
  end

  assign fabric_pin_out = pin_out_q;
  assign fabric_interrupt_a = irq_a_q;
  assign fabric_interrupt_b = irq_b_q;
  assign adc_conversion_start = adc_start_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB read path
  //
  // Reads are answered without wait states. The read value is taken
  // in the setup cycle, so a word is seen as it stood one cycle
  // before the access; a data output read therefore trails the
  // element outputs by two cycles.
  ////////////////////////////////////////////////////////////////////////////

  reg [31:0] rd_mux;
  reg [31:0] prdata_q;

  // Read value chosen from the address, reserved bits as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (elem_hit) begin
      rd_mux = {21'h000000, elem_ctrl_q[elem_idx]};
    end else begin
      case (paddr)
        `PLA_OFS_CLK_SEL: rd_mux = {25'h0000000, clk_sel_q};
        `PLA_OFS_IRQ_ROUTE: rd_mux = {19'h00000, irq_route_q};
        `PLA_OFS_ADC_ROUTE: rd_mux = {27'h0000000, adc_route_q};
        `PLA_OFS_DATA_IN: rd_mux = {16'h0000, data_in_q};
        `PLA_OFS_DATA_OUT: rd_mux = {16'h0000, data_out_q};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Captured in the setup cycle so read data comes from a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = apb_access & ~addr_hit;
  assign prdata = prdata_q;

endmodule
`default_nettype wire

// >>> tb/pla_partner.sv
// Far-side model: element input pins and external clock sources
`timescale 1ns/10ps
`default_nettype none
module pla_partner (
  // Bench side
  input wire logic pclk,
  input wire logic [4:0] run,
  input wire logic [15:0] pin_val,
  // Fabric side
  output logic [4:0] src_clk,
  output logic [15:0] pin_in
);
  logic [2:0] cnt_q = 3'h0;
  logic [4:0] clk_q = 5'h00;
  // Stopped sources stay low; running ones hold each level three cycles
  always @(posedge pclk) begin
    cnt_q <= (cnt_q == 3'h5) ? 3'h0 : cnt_q + 3'h1;
    clk_q <= run & {5{cnt_q < 3'h3}};
  end
  // Sources and pins toward the fabric
  assign src_clk = clk_q;
  assign pin_in = pin_val;
endmodule
`default_nettype wire

// >>> tb/pla_fabric_checker.sv
// Port assertions for the logic fabric
`timescale 1ns/10ps
`default_nettype none
module pla_fabric_checker (
  // Clock, reset, bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // Routed outputs
  input wire logic [13:0] fabric_pin_out,
  input wire logic fabric_interrupt_a,
  input wire logic adc_conversion_start
);
  logic acc;
  logic [12:0] irq_q;
  logic [4:0] adc_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of a transfer
  assign acc = psel && penable;
  // Routing shadows, updated at the same edge as the design's registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 13'h0000;
      adc_q <= 5'h00;
    end else begin
      irq_q <= (acc && pwrite && paddr == 8'h44) ? pwdata[12:0] : irq_q;
      adc_q <= (acc && pwrite && paddr == 8'h48) ? pwdata[4:0] : adc_q;
    end
  end
  ////////////////////
  AST_UNMAP: assert property (acc && paddr > 8'h50 |-> pslverr)
    else $error("unmapped without error");
  AST_MAPPED: assert property (acc && paddr <= 8'h50 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped with error");
  AST_UNMAP_RD: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_ELEM_RSV: assert property (acc && !pwrite && paddr < 8'h40 |-> prdata[31:11] == 21'h0)
    else $error("element spare bits set");
  AST_DOUT_RSV: assert property (acc && !pwrite && paddr == 8'h50 |-> prdata[31:16] == 16'h0)
    else $error("data out spare bits set");
  AST_IRQA_OFF: assert property (!irq_q[4] && !$past(irq_q[4]) |-> !fabric_interrupt_a)
    else $error("interrupt while disabled");
  AST_ADC_OFF: assert property (!adc_q[4] && !$past(adc_q[4]) |-> !adc_conversion_start)
    else $error("start while disabled");
  AST_IRQA_SRC: assert property (irq_q[4:0] == 5'h10 && $past(irq_q[4:0]) == 5'h10 |->
    fabric_interrupt_a == fabric_pin_out[0]) else $error("interrupt not element 0");
  AST_ADC_SRC: assert property (adc_q == 5'h18 && $past(adc_q) == 5'h18 |->
    adc_conversion_start == fabric_pin_out[6]) else $error("start not element 8");
endmodule
bind pla_fabric pla_fabric_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .prdata(prdata), .fabric_pin_out(fabric_pin_out), .fabric_interrupt_a(fabric_interrupt_a),
  .adc_conversion_start(adc_conversion_start));
`default_nettype wire

// >>> tb/pla_fabric_test.sv
// Self-checking bench for the logic fabric
`timescale 1ns/10ps
`default_nettype none
module pla_fabric_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, x;
  logic pready, pslverr, irq_a, irq_b, adc_st;
  logic [13:0] pin_out;
  logic [4:0] run = 5'h00;
  logic [4:0] sclk;
  logic [15:0] pin_val = 16'h0000;
  logic [15:0] pin_in, e;
  logic [3:0] tt;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int i, k, src, tgt;
  // Design and far side
  pla_fabric dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .fabric_pin_in(pin_in), .gpio_clk_p05(sclk[0]), .gpio_clk_p00(sclk[1]),
    .gpio_clk_p07(sclk[2]), .oscillator_clock(sclk[3]), .timer1_tick(sclk[4]),
    .fabric_pin_out(pin_out), .fabric_interrupt_a(irq_a), .fabric_interrupt_b(irq_b),
    .adc_conversion_start(adc_st));
  pla_partner far_u (.pclk(pclk), .run(run), .pin_val(pin_val), .src_clk(sclk),
    .pin_in(pin_in));
  // 250 MHz clock
  always #2 pclk = ~pclk;
  // A hang counts as a mismatch
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      mismatches++;
      end_sim();
    end
  end
  ////////////////////
  // One APB transfer; read data lands in rd
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Compare one value
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
    compares++;
    if (g !== ex) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, ex, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Counts, verdict, stop
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////
  // Test sequence
  initial begin
    idle(4);
    presetn <= 1'b1;
    for (i = 0; i < 22; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk("reset", 32'h0, rd);
    end
    $display("reset test done");
    for (i = 0; i < 21; i++) begin
      apb(1'b1, 8'(i * 4), 32'hffffffff);
      apb(1'b0, 8'(i * 4), 32'h0);
      x = i < 16 ? 32'h7ff : i == 16 ? 32'h77 : i == 17 ? 32'h1f1f : 32'h0;
      x = i == 18 ? 32'h1f : i == 19 ? 32'hffff : x;
      chk("mask", x, rd);
      apb(1'b1, 8'(i * 4), 32'h0);
    end
    $display("mask test done");
    // Pin as first input, data-in bit as second, every lookup code
    for (k = 0; k < 64; k++) begin
      pin_val <= 16'(k[1]);
      apb(1'b1, 8'h4c, 32'(k[0]));
      apb(1'b1, 8'h00, 32'h21 | (32'(k[5:2]) << 1));
      idle(4);
      apb(1'b0, 8'h50, 32'h0);
      tt = k[5:2] == 2 ? 4'h4 : k[5:2] == 4 ? 4'h2 : 4'(k[5:2]);
      chk("lookup", 32'(tt[k[1:0]]), rd & 32'h1);
    end
    $display("lookup test done");
    // Block 1 walks every source while block 0 sits on a spare code and must hold
    apb(1'b1, 8'h00, 32'h38);
    apb(1'b1, 8'h20, 32'h38);
    for (k = 0; k < 7; k++) begin
      apb(1'b1, 8'h40, k < 6 ? 32'(k << 4) | 32'h7 : 32'h67);
      run <= k < 3 ? 5'(1 << k) : k == 3 ? 5'h0 : k < 6 ? 5'(1 << (k - 1)) : 5'h1f;
      pin_val <= k[0] ? 16'h0000 : 16'h0101;
      idle(30);
      apb(1'b0, 8'h50, 32'h0);
      chk("clock", k[0] || k == 6 ? 32'h0 : 32'h100, rd);
    end
    $display("clock test done");
    // Each feedback code of both blocks, sources driven from pins
    run <= 5'h00;
    for (i = 0; i < 16; i++) apb(1'b1, 8'(i * 4), 32'h39);
    apb(1'b1, 8'h44, 32'h10);
    apb(1'b1, 8'h48, 32'h18);
    for (k = 0; k < 16; k++) begin
      tgt = k[3] ? 8 : 0;
      src = 2 * k[1:0] + 8 * k[3] + k[2];
      src = (k[2:0] == 0) ? (k[3] ? 7 : 15) : src;
      pin_val <= 16'(1 << src);
      apb(1'b1, 8'(tgt * 4), k[2] ? (32'(k[1:0]) << 7) | 32'h55 : (32'(k[1:0]) << 9) | 32'h19);
      idle(4);
      e = 16'(1 << src) | 16'(1 << tgt);
      apb(1'b0, 8'h50, 32'h0);
      chk("feedback", 32'(e), rd);
      chk("pins", 32'({e[15:8], e[5:0]}), 32'(pin_out));
      chk("routes", 32'({tgt == 0, 1'b0, tgt == 8}), 32'({irq_a, irq_b, adc_st}));
      apb(1'b1, 8'(tgt * 4), 32'h39);
    end
    apb(1'b1, 8'h44, 32'h1010);
    pin_val <= 16'h0001;
    idle(4);
    chk("irq b", 32'h1, 32'(irq_b));
    $display("route test done");
    end_sim();
  end
endmodule
`default_nettype wire
